// *** logic/light_conversion_mode_status.v ***
// Conversion mode sequencing and status flags, with Avalon-MM registers
`timescale 1ns/100ps
`include "lcms_regs.vh"
module light_conversion_mode_status #(
  parameter CNT_W = 27,
  parameter SHORT_CYC = `CT_SHORT_MS * `CLK_CYC_PER_MS,
  parameter LONG_CYC = `CT_LONG_MS * `CLK_CYC_PER_MS
) (
  // Clock and reset
  input wire CLK,
  input wire RST_B,
  // Avalon-MM slave
  input wire [4:0] ADDRESS,
  input wire READ,
  input wire WRITE,
  input wire [31:0] WRITEDATA,
  output reg [31:0] READDATA,
  output reg WAITREQUEST,
  // Converter side
  input wire OVERLOAD,
  input wire [15:0] RESULT,
  output reg CONV_ACTIVE,
  output reg [3:0] CONV_RANGE,
  // Interrupt
  output reg IRQ
);

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  reg state_q;
  reg [3:0] range_select_q;
  reg conversion_time_select_q;
  reg [1:0] mode_q;
  reg [1:0] fault_count_setting_q;
  reg [15:0] high_limit_q;
  reg overflow_flag_q;
  reg conversion_ready_flag_q;
  reg ovl_seen_q;
  reg [3:0] range_now_q;
  reg [2:0] irq_status_q;
  reg [2:0] irq_mask_q;
  reg high_prev_q;
  reg ovl_meta_q;
  reg ovl_sync_q;
  reg [15:0] res_meta_q;
  reg [15:0] res_sync_q;
  reg [1:0] settle_q;

  wire req;
  wire access;
  wire wr_cfg;
  wire rd_cfg;
  wire [1:0] wr_mode;
  wire auto_rng;
  wire timer_done;
  wire high_limit_flag;
  wire step_up;
  wire finish;
  wire ovl_live;
  reg start_conv;
  reg stop_conv;
  reg [3:0] start_range;
  reg [2:0] irq_set;
  reg [15:0] cfg_word;
  reg [31:0] rdata_d;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  // Converter pins come from the analog side, so two flops first
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ovl_meta_q <= 1'b0;
      ovl_sync_q <= 1'b0;
      res_meta_q <= 16'h0000;
      res_sync_q <= 16'h0000;
    end else begin
      ovl_meta_q <= OVERLOAD;
      ovl_sync_q <= ovl_meta_q;
      res_meta_q <= RESULT;
      res_sync_q <= res_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus access decode

  // Transfer completes on the edge where waitrequest is seen low
  assign req = READ | WRITE;
  assign access = req & ~WAITREQUEST;
  assign wr_cfg = access & WRITE & (ADDRESS == `OFS_CONFIG);
  assign rd_cfg = access & READ & (ADDRESS == `OFS_CONFIG);
  assign wr_mode = WRITEDATA[`CFG_MODE_HI:`CFG_MODE_LO];
  assign auto_rng = (range_select_q == `RANGE_AUTO);

  // One wait state, then one answer cycle
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      WAITREQUEST <= 1'b1;
      READDATA <= 32'h00000000;
    end else begin
      WAITREQUEST <= ~(req & WAITREQUEST);
      if (req & WAITREQUEST) begin
        READDATA <= rdata_d;
      end
    end
  end

  // Configuration word as software sees it; bits 5:2 read zero here
  always @* begin
    cfg_word = 16'h0000;
    cfg_word[`CFG_RANGE_HI:`CFG_RANGE_LO] = range_select_q;
    cfg_word[`CFG_CT_BIT] = conversion_time_select_q;
    cfg_word[`CFG_MODE_HI:`CFG_MODE_LO] = mode_q;
    cfg_word[`CFG_OVF_BIT] = overflow_flag_q;
    cfg_word[`CFG_CRF_BIT] = conversion_ready_flag_q;
    cfg_word[`CFG_FH_BIT] = high_limit_flag;
    cfg_word[`CFG_FC_HI:`CFG_FC_LO] = fault_count_setting_q;
  end

  // Read mux; unmapped addresses answer zero
  always @* begin
    case (ADDRESS)
      `OFS_CONFIG: rdata_d = {16'h0000, cfg_word};
      `OFS_HIGH_LIMIT: rdata_d = {16'h0000, high_limit_q};
      `OFS_IRQ_STATUS: rdata_d = {29'h00000000, irq_status_q};
      `OFS_IRQ_MASK: rdata_d = {29'h00000000, irq_mask_q};
      `OFS_RANGE_NOW: rdata_d = {28'h0000000, range_now_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencing

  // Auto ranging steps up only below the top range
  assign step_up = (state_q == ST_RUN) & auto_rng & ovl_live &
    (range_now_q < `RANGE_MAX);
  assign finish = (state_q == ST_RUN) & timer_done & ~step_up;
  assign ovl_live = ovl_sync_q & (settle_q == 2'h0); // Not from old range

  // Start, stop and next range for the timer
  always @* begin
    start_conv = 1'b0;
    stop_conv = 1'b0;
    start_range = auto_rng ? `RANGE_MIN : range_select_q;
    if (wr_cfg) begin
      if (wr_mode == `MODE_SHUTDOWN) begin
        stop_conv = 1'b1;
      end else begin
        start_conv = 1'b1;
      end
      if (WRITEDATA[`CFG_RANGE_HI:`CFG_RANGE_LO] == `RANGE_AUTO) begin
        start_range = `RANGE_MIN;
      end else begin
        start_range = WRITEDATA[`CFG_RANGE_HI:`CFG_RANGE_LO];
      end
    end else if (step_up) begin
      start_conv = 1'b1;
      start_range = range_now_q + 4'h1;
    end else if (finish & mode_q[1]) begin
      start_conv = 1'b1;
    end
  end

  // Mode field, settings and run state
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_q <= ST_IDLE;
      mode_q <= `MODE_RST;
      range_select_q <= `RANGE_RST;
      conversion_time_select_q <= `CT_RST;
      fault_count_setting_q <= `FC_RST;
      high_limit_q <= `HLIM_RST;
      range_now_q <= `RANGE_RST;
    end else begin
      if (start_conv) begin
        range_now_q <= start_range;
      end
      case (state_q)
        ST_IDLE: begin
          if (start_conv) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (stop_conv) begin
            state_q <= ST_IDLE;
          end else if (finish & ~start_conv) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      if (wr_cfg) begin
        mode_q <= wr_mode;
        range_select_q <= WRITEDATA[`CFG_RANGE_HI:`CFG_RANGE_LO];
        conversion_time_select_q <= WRITEDATA[`CFG_CT_BIT];
        fault_count_setting_q <= WRITEDATA[`CFG_FC_HI:`CFG_FC_LO];
      end else if (finish & (mode_q == `MODE_SINGLE)) begin
        mode_q <= `MODE_SHUTDOWN;
      end
      if (access & WRITE & (ADDRESS == `OFS_HIGH_LIMIT)) begin
        high_limit_q <= WRITEDATA[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Overflow and ready flags

  // Overload latch per attempt; stale pin value ignored after each start
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ovl_seen_q <= 1'b0;
      overflow_flag_q <= 1'b0;
      settle_q <= 2'h0;
    end else begin
      if (start_conv) begin
        ovl_seen_q <= 1'b0;
        settle_q <= `SETTLE_CYC;
      end else if (settle_q != 2'h0) begin
        settle_q <= settle_q - 2'h1;
      end else if ((state_q == ST_RUN) & ovl_sync_q) begin
        ovl_seen_q <= 1'b1;
      end
      // Auto mode reaches here only without overload or at top range
      if (finish) begin
        overflow_flag_q <= ovl_seen_q | ovl_live;
      end
    end
  end

  // Set beats clear; a read clears only a flag that it returned as set
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      conversion_ready_flag_q <= 1'b0;
    end else if (finish) begin
      conversion_ready_flag_q <= 1'b1;
    end else if ((rd_cfg & READDATA[`CFG_CRF_BIT]) |
      (wr_cfg & (wr_mode != `MODE_SHUTDOWN))) begin
      conversion_ready_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and output

  // Events: conversion end, high flag rising, overflow at end
  always @* begin
    irq_set = 3'h0;
    irq_set[`IRQ_DONE] = finish;
    irq_set[`IRQ_HIGH] = high_limit_flag & ~high_prev_q;
    irq_set[`IRQ_OVF] = finish & (ovl_seen_q | ovl_live);
  end

  // Write one to clear; a same-cycle event keeps its bit
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_status_q <= 3'h0;
      irq_mask_q <= `MASK_RST;
      high_prev_q <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      high_prev_q <= high_limit_flag;
      if (access & WRITE & (ADDRESS == `OFS_IRQ_STATUS)) begin
        irq_status_q <= (irq_status_q & ~WRITEDATA[2:0]) | irq_set;
      end else begin
        irq_status_q <= irq_status_q | irq_set;
      end
      if (access & WRITE & (ADDRESS == `OFS_IRQ_MASK)) begin
        irq_mask_q <= WRITEDATA[2:0];
      end
      // Output lags status by one cycle to come from a flop
      IRQ <= |(irq_status_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Converter-facing outputs

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      CONV_ACTIVE <= 1'b0;
      CONV_RANGE <= `RANGE_RST;
    end else begin
      CONV_ACTIVE <= (state_q == ST_RUN);
      CONV_RANGE <= range_now_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Submodules

  conv_timer #(
    .CNT_W(CNT_W),
    .SHORT_CYC(SHORT_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_timer (
    .clk(CLK),
    .rst_b(RST_B),
    .start(start_conv),
    .stop(stop_conv),
    .len_long(wr_cfg ? WRITEDATA[`CFG_CT_BIT] : conversion_time_select_q),
    .done_q(timer_done),
    .busy_q()
  );

  fault_limit #(
    .DW(16)
  ) u_high (
    .clk(CLK),
    .rst_b(RST_B),
    .measure(finish),
    .result(res_sync_q),
    .limit(high_limit_q),
    .fault_count_setting(fault_count_setting_q),
    .flag_q(high_limit_flag)
  );

endmodule

// *** logic/lcms_regs.vh ***
// Register map, field layout, reset values and timing of the mode block
`ifndef LCMS_REGS_VH
`define LCMS_REGS_VH

// Word-aligned byte offsets on the register bus
`define OFS_CONFIG 5'h00
`define OFS_HIGH_LIMIT 5'h04
`define OFS_IRQ_STATUS 5'h08
`define OFS_IRQ_MASK 5'h0c
`define OFS_RANGE_NOW 5'h10

// Configuration word field positions
`define CFG_RANGE_HI 15
`define CFG_RANGE_LO 12
`define CFG_CT_BIT 11
`define CFG_MODE_HI 10
`define CFG_MODE_LO 9
`define CFG_OVF_BIT 8
`define CFG_CRF_BIT 7
`define CFG_FH_BIT 6
`define CFG_FC_HI 1
`define CFG_FC_LO 0

// Conversion mode codes
`define MODE_SHUTDOWN 2'h0
`define MODE_SINGLE 2'h1

// Range select codes
`define RANGE_AUTO 4'hc
`define RANGE_MAX 4'hb
`define RANGE_MIN 4'h0

// Reset values
`define RANGE_RST 4'hc
`define CT_RST 1'h1
`define MODE_RST 2'h0
`define FC_RST 2'h0
`define HLIM_RST 16'hffff
`define MASK_RST 3'h0

// Interrupt status bit positions
`define IRQ_DONE 0
`define IRQ_HIGH 1
`define IRQ_OVF 2

// Conversion times in ms, clock in cycles per ms
`define CT_SHORT_MS 100
`define CT_LONG_MS 800
`define CLK_CYC_PER_MS 100000

// Cycles of stale overload after a start: range flop plus two sync flops
`define SETTLE_CYC 2'h3

`endif

// *** logic/conv_timer.v ***
// Integration timer: counts one conversion period and pulses at its end
`timescale 1ns/100ps
`include "lcms_regs.vh"
module conv_timer #(
  parameter CNT_W = 27,
  parameter SHORT_CYC = `CT_SHORT_MS * `CLK_CYC_PER_MS,
  parameter LONG_CYC = `CT_LONG_MS * `CLK_CYC_PER_MS
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Control
  input wire start,
  input wire stop,
  input wire len_long,
  // Status
  output reg done_q,
  output reg busy_q
);

  reg [CNT_W-1:0] count_q;
  wire [CNT_W-1:0] short_load;
  wire [CNT_W-1:0] long_load;

  // Two less: done flop and finish edge each add one; periods must be >= 2
  assign short_load = SHORT_CYC[CNT_W-1:0] - {{(CNT_W-2){1'b0}}, 2'b10};
  assign long_load = LONG_CYC[CNT_W-1:0] - {{(CNT_W-2){1'b0}}, 2'b10};

  // Start reloads even when busy, so an abort-restart needs no idle gap
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= {CNT_W{1'b0}};
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        count_q <= len_long ? long_load : short_load;
        busy_q <= 1'b1;
      end else if (stop) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        if (count_q == {CNT_W{1'b0}}) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          count_q <= count_q - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// *** logic/fault_limit.v ***
// Consecutive-exceedance counter behind the high-limit flag
`timescale 1ns/100ps
module fault_limit #(
  parameter DW = 16
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Measurement in
  input wire measure,
  input wire [DW-1:0] result,
  input wire [DW-1:0] limit,
  input wire [1:0] fault_count_setting,
  // Flag out
  output reg flag_q
);

  reg [3:0] count_q;
  wire [3:0] count_inc;

  // Consecutive events needed for each fault count code
  function [3:0] needed;
    input [1:0] code;
    begin
      case (code)
        2'h0: needed = 4'h1;
        2'h1: needed = 4'h2;
        2'h2: needed = 4'h4;
        default: needed = 4'h8;
      endcase
    end
  endfunction

  assign count_inc = (count_q == 4'h8) ? count_q : count_q + 4'h1;

  // Only a measurement moves the flag; shutdown leaves it standing
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= 4'h0;
      flag_q <= 1'b0;
    end else if (measure) begin
      if (result > limit) begin
        count_q <= count_inc;
        if (count_inc >= needed(fault_count_setting)) begin
          flag_q <= 1'b1;
        end
      end else begin
        count_q <= 4'h0;
        flag_q <= 1'b0;
      end
    end
  end

endmodule

// *** bench/lcms_properties.sv ***
// Port-level properties of the conversion mode and status block
`timescale 1ns/100ps
module lcms_properties (
  // Clock and reset
  input wire CLK,
  input wire RST_B,
  // Register bus
  input wire [4:0] ADDRESS,
  input wire READ,
  input wire WRITE,
  input wire [31:0] WRITEDATA,
  input wire [31:0] READDATA,
  input wire WAITREQUEST,
  // Converter and interrupt
  input wire OVERLOAD,
  input wire [15:0] RESULT,
  input wire CONV_ACTIVE,
  input wire [3:0] CONV_RANGE,
  input wire IRQ
);
  reg [3:0] rng_q;
  reg [2:0] age_q;
  wire req = READ || WRITE;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////////////////////////////////////////
  // Last written range; age masks the lag right after any write
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rng_q <= 4'hc;
      age_q <= 3'h0;
    end else if (WRITE && !WAITREQUEST) begin
      if (ADDRESS == 5'h00)
        rng_q <= WRITEDATA[15:12];
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_wait_after_req: assert property (req && WAITREQUEST |=> !WAITREQUEST)
    else $error("no answer one cycle after request");
  a_wait_one_low: assert property (!WAITREQUEST |=> WAITREQUEST)
    else $error("wait request low too long");
  a_no_spur_ack: assert property (!req && WAITREQUEST |=> WAITREQUEST)
    else $error("answer without request");
  a_unmapped_zero: assert property (READ && WAITREQUEST &&
    ADDRESS >= 5'h14 |=> READDATA == 32'h0)
    else $error("unmapped read not zero");
  a_manual_range: assert property (
    CONV_ACTIVE && age_q > 3'h3 && rng_q < 4'hc |-> CONV_RANGE == rng_q)
    else $error("fixed range not applied");
  a_auto_cap: assert property (
    CONV_ACTIVE && age_q > 3'h3 && rng_q == 4'hc |-> CONV_RANGE <= 4'hb)
    else $error("auto range beyond maximum");
  a_auto_step: assert property (
    CONV_ACTIVE && $past(CONV_ACTIVE) && age_q > 3'h3 && rng_q == 4'hc &&
    CONV_RANGE != $past(CONV_RANGE) |->
    CONV_RANGE == 4'h0 || CONV_RANGE - $past(CONV_RANGE) == 4'h1)
    else $error("auto range skipped a step");
  a_irq_hold: assert property ($fell(IRQ) |-> age_q < 3'h4)
    else $error("interrupt dropped without a write");
  c_cfg_read: cover property (READ && !WAITREQUEST && ADDRESS == 5'h00);
  c_conv_end: cover property ($fell(CONV_ACTIVE));
  c_irq_up: cover property ($rose(IRQ));
  c_top_range: cover property (CONV_ACTIVE && CONV_RANGE == 4'hb);
endmodule

// *** bench/conv_model.sv ***
// Converter front end model: overload and result seen by the block
`timescale 1ns/100ps
module conv_model (
  // Clock
  input wire clk,
  // Conversion state from the block
  input wire active,
  input wire [3:0] range,
  // Scene set by the bench
  input wire [3:0] need,
  input wire spike,
  input wire [15:0] level,
  // Converter outputs
  output wire overload,
  output reg [15:0] result
);
  reg [7:0] run_q;
  reg [2:0] hold_q;
  initial begin
    run_q = 8'h0;
    hold_q = 3'h0;
    result = 16'h0;
  end
  // Too low a range overloads at once; a spike hits early integration only
  assign overload = active &&
    (range < need || (spike && run_q > 8'h2 && run_q < 8'h6));
  // Result held just past the end, then scrambled every cycle
  always @(posedge clk) begin
    run_q <= active ? run_q + 8'h1 : 8'h0;
    hold_q <= active ? 3'h5 : (hold_q != 3'h0 ? hold_q - 3'h1 : 3'h0);
    result <= (active || hold_q != 3'h0) ? level : ~result;
  end
endmodule

// *** bench/test_light_conversion_mode_status.sv ***
// Self-checking bench for the conversion mode and status block
`timescale 1ns/100ps
`include "lcms_regs.vh"
module test_light_conversion_mode_status;
  reg CLK, RST_B, READ, WRITE, spike;
  reg [4:0] ADDRESS;
  reg [31:0] WRITEDATA, q;
  reg [15:0] level;
  reg [3:0] need, r;
  wire [31:0] READDATA;
  wire [15:0] RESULT;
  wire [3:0] CONV_RANGE;
  wire WAITREQUEST, OVERLOAD, CONV_ACTIVE, IRQ;
  integer mismatches, cmp_count, seed, i, k, n;
  light_conversion_mode_status #(.SHORT_CYC(20), .LONG_CYC(40))
    light_conversion_mode_status_inst (.CLK(CLK), .RST_B(RST_B),
    .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
    .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .OVERLOAD(OVERLOAD),
    .RESULT(RESULT), .CONV_ACTIVE(CONV_ACTIVE), .CONV_RANGE(CONV_RANGE),
    .IRQ(IRQ));
  conv_model conv_model_inst (.clk(CLK), .active(CONV_ACTIVE),
    .range(CONV_RANGE), .need(need), .spike(spike), .level(level),
    .overload(OVERLOAD), .result(RESULT));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  end
  endtask
  // One transfer; request held until wait request is seen low
  task bus(input w, input [4:0] a, input [31:0] d);
  begin
    @(posedge CLK);
    ADDRESS <= a;
    WRITEDATA <= d;
    WRITE <= w;
    READ <= !w;
    n = 0;
    @(posedge CLK);
    while (WAITREQUEST !== 1'b0 && n < 20) begin
      n = n + 1;
      @(posedge CLK);
    end
    chk(n < 20, 1);
    q = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
  end
  endtask
  task wait_irq;
  begin
    n = 0;
    while (IRQ !== 1'b1 && n < 300) begin
      n = n + 1;
      @(posedge CLK);
    end
    chk(n < 300, 1);
  end
  endtask
  function [15:0] cfg(input [3:0] rg, input ct, input [1:0] m,
    input [1:0] fc);
    cfg = {rg, ct, m, 7'h0, fc};
  endfunction
  // Single shot to completion; leaves the config word in q
  task shot(input [15:0] c);
  begin
    bus(1, `OFS_CONFIG, c);
    wait_irq;
    bus(1, `OFS_IRQ_STATUS, 32'h7);
    bus(0, `OFS_CONFIG, 0);
  end
  endtask
  task wrap_up;
  begin
    $display("checks %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  initial begin
    #100000;
    mismatches = mismatches + 1;
    wrap_up;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h799d;
    {mismatches, cmp_count} = 0;
    {READ, WRITE, spike, ADDRESS, WRITEDATA, need, RST_B} = 0;
    level = 16'h1234;
    repeat (10) @(posedge CLK);
    RST_B <= 1'b1;
    bus(0, `OFS_CONFIG, 0);
    chk(q, 32'hc800);
    bus(0, `OFS_HIGH_LIMIT, 0);
    chk(q, 32'hffff);
    bus(1, 5'h14, 32'h1);
    bus(0, 5'h14, 0);
    chk(q, 0);
    bus(1, `OFS_IRQ_MASK, 32'h1);
    // Fixed ranges, spike on odd passes so the flag must also clear
    for (i = 0; i < 4; i = i + 1) begin
      r = $unsigned($random(seed)) % 12;
      spike <= i[0];
      bus(1, `OFS_CONFIG, cfg(r, 0, 1, 0));
      bus(0, `OFS_CONFIG, 0);
      chk(q[10:9], 1);
      wait_irq;
      bus(1, `OFS_CONFIG, cfg(r, 0, 0, 0));
      chk(IRQ, 1);
      bus(0, `OFS_CONFIG, 0);
      chk(q[10:7], {3'b000, i[0], 1'b1});
      bus(1, `OFS_IRQ_STATUS, 32'h7);
    end
    spike <= 1'b0;
    // Continuous codes; a nonzero write and a read each clear ready
    for (i = 2; i < 4; i = i + 1) begin
      bus(1, `OFS_CONFIG, cfg(0, 0, i[1:0], 0));
      wait_irq;
      bus(1, `OFS_IRQ_STATUS, 32'h7);
      bus(1, `OFS_CONFIG, cfg(0, 0, i[1:0], 0));
      bus(0, `OFS_CONFIG, 0);
      chk(q[10:7], {i[1:0], 2'b00});
      wait_irq;
      bus(1, `OFS_IRQ_STATUS, 32'h7);
      bus(0, `OFS_CONFIG, 0);
      chk(q[7], 1);
      bus(0, `OFS_CONFIG, 0);
      chk(q[7], 0);
      bus(1, `OFS_CONFIG, 0);
      bus(1, `OFS_IRQ_STATUS, 32'h7);
    end
    // Auto ranging: settles on the needed range or overflows at the top
    for (i = 0; i < 2; i = i + 1) begin
      need <= i[0] ? 4'hd : 4'h5;
      shot(cfg(4'hc, 0, 1, 0));
      chk(q[8], i[0]);
      bus(0, `OFS_RANGE_NOW, 0);
      chk(q, i[0] ? 4'hb : 4'h5);
    end
    need <= 4'h0;
    // Conversion length for both time settings
    for (i = 0; i < 2; i = i + 1) begin
      bus(1, `OFS_CONFIG, cfg(0, i[0], 1, 0));
      while (CONV_ACTIVE !== 1'b1) @(posedge CLK);
      k = 0;
      while (CONV_ACTIVE === 1'b1 && k < 100) begin
        k = k + 1;
        @(posedge CLK);
      end
      chk(k, i[0] ? 40 : 20);
      wait_irq;
    end
    // Masking hides a pending event; clearing removes it
    bus(1, `OFS_IRQ_MASK, 0);
    bus(0, `OFS_IRQ_STATUS, 0);
    chk(q[0] && !IRQ, 1);
    bus(1, `OFS_IRQ_MASK, 32'h1);
    bus(0, `OFS_IRQ_MASK, 0);
    chk(IRQ, 1);
    bus(1, `OFS_IRQ_STATUS, 32'h7);
    bus(0, `OFS_IRQ_STATUS, 0);
    chk(IRQ, 0);
    // High flag needs exactly 1, 2, 4 or 8 exceedances in a row
    for (k = 0; k < 4; k = k + 1) begin
      level <= 16'h0100 + ($random(seed) & 16'h7fff);
      @(posedge CLK);
      bus(1, `OFS_HIGH_LIMIT, level);
      shot(cfg(0, 0, 1, k[1:0]));
      chk(q[6], 0);
      bus(1, `OFS_HIGH_LIMIT, level - 16'h1);
      for (i = 0; i < (1 << k); i = i + 1) begin
        shot(cfg(0, 0, 1, k[1:0]));
        chk(q[6], i == (1 << k) - 1);
      end
    end
    wrap_up;
  end
endmodule
bind light_conversion_mode_status lcms_properties lcms_properties_inst (
  .CLK(CLK), .RST_B(RST_B), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
  .WRITEDATA(WRITEDATA), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
  .OVERLOAD(OVERLOAD), .RESULT(RESULT), .CONV_ACTIVE(CONV_ACTIVE),
  .CONV_RANGE(CONV_RANGE), .IRQ(IRQ));
